// ==== design/ttc_defs.svh ====
// Register offsets, field positions, reset values and timing counts for the triple timer counter
// Functional notes
// - Timers zero and one tick at one sixth clock, timer two counts every clock
// - Counter counts sampled high-then-low pin transitions
// - Bit 2 and bit 6 choose pin source
// - Gate bit adds qualify pin high condition
// - Two mode bits pick one of four modes
// - Mode one rolls sixteen bits, sets flag
// - Mode two reloads low from high byte
// - Only timers one and two may clock the serial port
// - Timer one frozen in mode three
// - Timer zero mode three splits two bytes
// - Timer one runs by leaving mode three
// - Timer two sixteen bits plus capture pair
// - Timer two source bit one, run bit two
// - Timer two overflow flag, software clear, baud blocks
// - External flag set on enabled trigger fall
// - Bit five picks receive baud source
// - Bit four picks transmit baud source
// - Timer two flags raise gated interrupt
// - Timer zero and one overflow flags cleared on vector entry
`ifndef TTC_DEFS_SVH
`define TTC_DEFS_SVH

`define TTC_ADDR_W 8
`define TTC_OFF_MODE 8'h89
`define TTC_OFF_RUNFLAG 8'h88
`define TTC_OFF_T0LO 8'h8A
`define TTC_OFF_T1LO 8'h8B
`define TTC_OFF_T0HI 8'h8C
`define TTC_OFF_T1HI 8'h8D
`define TTC_OFF_T2CTL 8'hC8
`define TTC_OFF_T2MODE 8'hC9
`define TTC_OFF_CAPLO 8'hCA
`define TTC_OFF_CAPHI 8'hCB
`define TTC_OFF_T2LO 8'hCC
`define TTC_OFF_T2HI 8'hCD

`define TTC_RST_BYTE 8'h00

// Mode configuration fields
`define TTC_M_GATE1 7
`define TTC_M_SRC1 6
`define TTC_M_SRC0 2
`define TTC_M_GATE0 3

// Run/flag control fields
`define TTC_RF_OVF1 7
`define TTC_RF_RUN1 6
`define TTC_RF_OVF0 5
`define TTC_RF_RUN0 4

// Timer two control fields
`define TTC_C_OVF 7
`define TTC_C_EXF 6
`define TTC_C_RXSEL 5
`define TTC_C_TXSEL 4
`define TTC_C_EXEN 3
`define TTC_C_RUN 2
`define TTC_C_SRC 1

// Timer clock: peripheral clock divided by six
`define TTC_DIV 6
`define TTC_DIV_MAX 3'h5

`endif

// ==== design/ttc_pkg.sv ====
// Types for the triple timer counter
package ttc_pkg;

    typedef enum logic [1:0] {
        TTC_MODE_13BIT,
        TTC_MODE_16BIT,
        TTC_MODE_RELOAD,
        TTC_MODE_SPLIT
    } ttc_mode_t;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } ttc_count_t;

    typedef struct packed {
        logic rx_tick;
        logic tx_tick;
    } ttc_baud_t;

endpackage

// ==== design/ttc_top.sv ====
// Three timer counters with byte-wide register port
`timescale 1ns/1ps
`include "ttc_defs.svh"

module ttc_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Event pins
    input wire logic ext_count_pin_a,
    input wire logic ext_count_pin_b,
    input wire logic qualify_pin_a,
    input wire logic qualify_pin_b,
    input wire logic timer_two_count_pin,
    input wire logic timer_two_trigger_pin,
    // Interrupt controller side
    input wire logic vector_t0,
    input wire logic vector_t1,
    input wire logic t2_irq_enable,
    input wire logic global_irq_enable,
    output logic t2_irq,
    // Serial port side and timer zero overflow pulse
    input wire logic uart_mode_var,
    output ttc_pkg::ttc_baud_t baud,
    output logic t0_ovf_pulse
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] mode_q, mode_d;
    logic [7:0] rf_q, rf_d;
    logic [7:0] ctl2_q, ctl2_d;
    logic [7:0] t2mode_q, t2mode_d;
    ttc_pkg::ttc_count_t c0_q, c0_d, c1_q, c1_d, c2_q, c2_d, cap_q, cap_d;
    logic [2:0] div_q, div_d;
    logic [3:0] samp_q, samp_d;
    logic [3:0] prev_q, prev_d;
    logic [7:0] rdata_q, rdata_d;
    ttc_pkg::ttc_baud_t baud_q, baud_d;
    logic t0p_q, t0p_d;

    // ----------------------------------------
    // Machine cycle and pin edges
    // ----------------------------------------
    logic tick;
    logic fall_a, fall_b, fall_t2, fall_ex;

    assign tick = (div_q == `TTC_DIV_MAX);

    always_comb begin
        div_d = tick ? 3'h0 : div_q + 3'h1;
        samp_d = samp_q;
        prev_d = prev_q;
        if (tick) begin
            samp_d = {timer_two_trigger_pin, timer_two_count_pin, ext_count_pin_b, ext_count_pin_a};
            prev_d = samp_q;
        end
    end

    // One sample high, next sample low
    assign fall_a = tick && prev_q[0] && !samp_q[0];
    assign fall_b = tick && prev_q[1] && !samp_q[1];
    assign fall_t2 = tick && prev_q[2] && !samp_q[2];
    assign fall_ex = tick && prev_q[3] && !samp_q[3];

    // ----------------------------------------
    // Count enables
    // ----------------------------------------
    ttc_pkg::ttc_mode_t m0, m1;
    logic src0_ev, src1_ev, en0, en1, en0h;
    logic split;

    assign m0 = ttc_pkg::ttc_mode_t'(mode_q[1:0]);
    assign m1 = ttc_pkg::ttc_mode_t'(mode_q[5:4]);
    assign split = (m0 == ttc_pkg::TTC_MODE_SPLIT);
    assign src0_ev = mode_q[`TTC_M_SRC0] ? fall_a : tick;
    assign src1_ev = mode_q[`TTC_M_SRC1] ? fall_b : tick;
    assign en0 = src0_ev && rf_q[`TTC_RF_RUN0] && (!mode_q[`TTC_M_GATE0] || qualify_pin_a);
    // Timer one loses its run bit while timer zero is split
    assign en1 = src1_ev && (split || rf_q[`TTC_RF_RUN1])
        && (!mode_q[`TTC_M_GATE1] || qualify_pin_b) && (m1 != ttc_pkg::TTC_MODE_SPLIT);
    assign en0h = split && tick && rf_q[`TTC_RF_RUN1];

    // ----------------------------------------
    // Shared counting function for timers zero and one
    // ----------------------------------------
    function automatic logic [16:0] ttc_step(input logic [15:0] v, input logic [1:0] m);
        logic [16:0] r;
        logic [13:0] s13;
        logic [8:0] s8;
        r = {1'b0, v};
        s13 = {1'b0, v[15:8], v[4:0]} + 14'h1;
        s8 = {1'b0, v[7:0]} + 9'h1;
        case (m)
            2'b00: r = {s13[13], s13[12:5], v[7:5], s13[4:0]};
            2'b01: r = {1'b0, v} + 17'h1;
            2'b10: r = {s8[8], v[15:8], s8[8] ? v[15:8] : s8[7:0]};
            default: r = {s8[8], v[15:8], s8[7:0]};
        endcase
        return r;
    endfunction

    logic [16:0] n0, n1;
    logic [8:0] n0h;
    logic [16:0] n2;
    logic ovf0, ovf1, ovf2, baud2;

    assign n0 = ttc_step(c0_q, mode_q[1:0]);
    assign n1 = ttc_step(c1_q, mode_q[5:4]);
    assign n0h = {1'b0, c0_q.hi} + 9'h1;
    assign ovf0 = en0 && n0[16];
    assign ovf1 = split ? (en0h && n0h[8]) : (en1 && n1[16]);
    // Timer one overflow, even when its flag is taken by the split timer
    logic t1_roll;
    assign t1_roll = en1 && n1[16];

    // ----------------------------------------
    // Timer two
    // ----------------------------------------
    logic en2;
    assign baud2 = ctl2_q[`TTC_C_RXSEL] || ctl2_q[`TTC_C_TXSEL];
    assign en2 = ctl2_q[`TTC_C_RUN] && (ctl2_q[`TTC_C_SRC] ? fall_t2 : 1'b1);
    assign n2 = {1'b0, c2_q} + 17'h1;
    assign ovf2 = en2 && n2[16];

    // ----------------------------------------
    // Register file and counters
    // ----------------------------------------
    always_comb begin
        mode_d = mode_q;
        rf_d = rf_q;
        ctl2_d = ctl2_q;
        t2mode_d = t2mode_q;
        c0_d = c0_q;
        c1_d = c1_q;
        c2_d = c2_q;
        cap_d = cap_q;
        if (wr) begin
            case (addr)
                `TTC_OFF_MODE: mode_d = wdata;
                `TTC_OFF_RUNFLAG: rf_d = wdata;
                `TTC_OFF_T2CTL: ctl2_d = wdata;
                `TTC_OFF_T2MODE: t2mode_d = wdata;
                `TTC_OFF_CAPLO: cap_d.lo = wdata;
                `TTC_OFF_CAPHI: cap_d.hi = wdata;
                `TTC_OFF_T0LO: c0_d.lo = wdata;
                `TTC_OFF_T0HI: c0_d.hi = wdata;
                `TTC_OFF_T1LO: c1_d.lo = wdata;
                `TTC_OFF_T1HI: c1_d.hi = wdata;
                `TTC_OFF_T2LO: c2_d.lo = wdata;
                `TTC_OFF_T2HI: c2_d.hi = wdata;
                default: ;
            endcase
        end
        // Hardware counting overrides a same-cycle write
        if (en0) begin
            if (split) begin
                c0_d.lo = n0[7:0];
            end else begin
                c0_d = n0[15:0];
            end
        end
        if (en0h) begin
            c0_d.hi = n0h[7:0];
        end
        if (en1) begin
            c1_d = n1[15:0];
        end
        if (en2) begin
            c2_d = n2[15:0];
        end
        // Vector entry clears, hardware set wins
        if (vector_t0) begin
            rf_d[`TTC_RF_OVF0] = 1'b0;
        end
        if (vector_t1) begin
            rf_d[`TTC_RF_OVF1] = 1'b0;
        end
        if (ovf0) begin
            rf_d[`TTC_RF_OVF0] = 1'b1;
        end
        if (ovf1) begin
            rf_d[`TTC_RF_OVF1] = 1'b1;
        end
        if (ovf2 && !baud2) begin
            ctl2_d[`TTC_C_OVF] = 1'b1;
        end
        if (fall_ex && ctl2_q[`TTC_C_EXEN]) begin
            ctl2_d[`TTC_C_EXF] = 1'b1;
        end
    end

    // ----------------------------------------
    // Read port, baud and interrupt outputs
    // ----------------------------------------
    always_comb begin
        rdata_d = `TTC_RST_BYTE;
        if (rd) begin
            case (addr)
                `TTC_OFF_MODE: rdata_d = mode_q;
                `TTC_OFF_RUNFLAG: rdata_d = rf_q;
                `TTC_OFF_T2CTL: rdata_d = ctl2_q;
                `TTC_OFF_T2MODE: rdata_d = t2mode_q;
                `TTC_OFF_CAPLO: rdata_d = cap_q.lo;
                `TTC_OFF_CAPHI: rdata_d = cap_q.hi;
                `TTC_OFF_T0LO: rdata_d = c0_q.lo;
                `TTC_OFF_T0HI: rdata_d = c0_q.hi;
                `TTC_OFF_T1LO: rdata_d = c1_q.lo;
                `TTC_OFF_T1HI: rdata_d = c1_q.hi;
                `TTC_OFF_T2LO: rdata_d = c2_q.lo;
                `TTC_OFF_T2HI: rdata_d = c2_q.hi;
                default: rdata_d = `TTC_RST_BYTE;
            endcase
        end
        // Timer zero never feeds the serial clocks
        baud_d.rx_tick = uart_mode_var && (ctl2_q[`TTC_C_RXSEL] ? ovf2 : t1_roll);
        baud_d.tx_tick = uart_mode_var && (ctl2_q[`TTC_C_TXSEL] ? ovf2 : t1_roll);
        t0p_d = ovf0;
    end

    assign rdata = rdata_q;
    assign baud = baud_q;
    assign t0_ovf_pulse = t0p_q;
    assign t2_irq = (ctl2_q[`TTC_C_OVF] || ctl2_q[`TTC_C_EXF]) && t2_irq_enable && global_irq_enable;

    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_q <= `TTC_RST_BYTE;
            rf_q <= `TTC_RST_BYTE;
            ctl2_q <= `TTC_RST_BYTE;
            t2mode_q <= `TTC_RST_BYTE;
            c0_q <= '0;
            c1_q <= '0;
            c2_q <= '0;
            cap_q <= '0;
            div_q <= 3'h0;
            samp_q <= 4'h0;
            prev_q <= 4'h0;
            rdata_q <= `TTC_RST_BYTE;
            baud_q <= '0;
            t0p_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            rf_q <= rf_d;
            ctl2_q <= ctl2_d;
            t2mode_q <= t2mode_d;
            c0_q <= c0_d;
            c1_q <= c1_d;
            c2_q <= c2_d;
            cap_q <= cap_d;
            div_q <= div_d;
            samp_q <= samp_d;
            prev_q <= prev_d;
            rdata_q <= rdata_d;
            baud_q <= baud_d;
            t0p_q <= t0p_d;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // Timer clock and pin sampling
    a_tick_period: assert property (@(posedge mclk) disable iff (rst)
        tick |=> (!tick) [*5] ##1 tick)
        else $error("timer tick period not six");
    a_div_range: assert property (@(posedge mclk) disable iff (rst)
        div_q <= `TTC_DIV_MAX)
        else $error("divider out of range");
    a_pin_edge: assert property (@(posedge mclk) disable iff (rst)
        fall_a |-> $past(samp_q[0], 6) && !samp_q[0])
        else $error("pin edge without high sample");
    a_pin_edge_b: assert property (@(posedge mclk) disable iff (rst)
        fall_b |-> $past(samp_q[1], 6) && !samp_q[1])
        else $error("pin b edge without high sample");

    // Count sources and gating
    a_src_internal: assert property (@(posedge mclk) disable iff (rst)
        en0 && !mode_q[`TTC_M_SRC0] |-> tick)
        else $error("internal source counted off tick");
    a_src_external: assert property (@(posedge mclk) disable iff (rst)
        en0 && mode_q[`TTC_M_SRC0] |-> fall_a)
        else $error("external source counted without edge");
    a_src_external_b: assert property (@(posedge mclk) disable iff (rst)
        en1 && mode_q[`TTC_M_SRC1] |-> fall_b)
        else $error("timer one counted without edge");
    a_gate_block: assert property (@(posedge mclk) disable iff (rst)
        mode_q[`TTC_M_GATE0] && !qualify_pin_a && !wr && !(split && rf_q[`TTC_RF_RUN1])
        |=> $stable(c0_q))
        else $error("gated timer zero advanced");
    a_run_off: assert property (@(posedge mclk) disable iff (rst)
        !rf_q[`TTC_RF_RUN0] |-> !en0)
        else $error("timer zero counted while stopped");

    // Timer zero and one modes
    a_ovf_set: assert property (@(posedge mclk) disable iff (rst)
        ovf0 |=> rf_q[`TTC_RF_OVF0])
        else $error("overflow flag not set");
    a_wrap16: assert property (@(posedge mclk) disable iff (rst)
        ovf0 && m0 == ttc_pkg::TTC_MODE_16BIT |=> c0_q == 16'h0000)
        else $error("sixteen bit wrap not zero");
    a_reload_low: assert property (@(posedge mclk) disable iff (rst)
        ovf0 && m0 == ttc_pkg::TTC_MODE_RELOAD |=> c0_q.lo == $past(c0_q.hi))
        else $error("reload value wrong");
    a_reload_high: assert property (@(posedge mclk) disable iff (rst)
        ovf0 && m0 == ttc_pkg::TTC_MODE_RELOAD |=> $stable(c0_q.hi))
        else $error("reload byte changed");
    a_no_t0_baud: assert property (@(posedge mclk) disable iff (rst)
        !t1_roll && !ovf2 |=> !baud_q.rx_tick && !baud_q.tx_tick)
        else $error("serial clock without timer one or two");
    a_t1_frozen: assert property (@(posedge mclk) disable iff (rst)
        m1 == ttc_pkg::TTC_MODE_SPLIT && !wr |=> $stable(c1_q))
        else $error("timer one moved in mode three");
    a_split_high: assert property (@(posedge mclk) disable iff (rst)
        en0h |=> c0_q.hi == 8'($past(c0_q.hi) + 8'h01))
        else $error("split high byte did not step");
    a_split_flag: assert property (@(posedge mclk) disable iff (rst)
        en0h && c0_q.hi == 8'hFF |=> rf_q[`TTC_RF_OVF1])
        else $error("split high byte flag not set");
    a_split_run: assert property (@(posedge mclk) disable iff (rst)
        split && m1 != ttc_pkg::TTC_MODE_SPLIT && src1_ev && !mode_q[`TTC_M_GATE1]
        |-> en1)
        else $error("timer one stopped while split");
    a_wrap13: assert property (@(posedge mclk) disable iff (rst)
        ovf0 && m0 == ttc_pkg::TTC_MODE_13BIT
        |=> c0_q.hi == 8'h00 && c0_q.lo[4:0] == 5'h00)
        else $error("thirteen bit wrap not zero");

    // Timer two
    a_t2_step: assert property (@(posedge mclk) disable iff (rst)
        en2 |=> c2_q == 16'($past(c2_q) + 16'h0001))
        else $error("timer two did not step");
    a_t2_hold: assert property (@(posedge mclk) disable iff (rst)
        !ctl2_q[`TTC_C_RUN] && !wr |=> $stable(c2_q))
        else $error("timer two moved while stopped");
    a_t2_src: assert property (@(posedge mclk) disable iff (rst)
        en2 && ctl2_q[`TTC_C_SRC] |-> fall_t2)
        else $error("timer two counted without edge");
    a_t2_flag_hold: assert property (@(posedge mclk) disable iff (rst)
        ctl2_q[`TTC_C_OVF] && !(wr && addr == `TTC_OFF_T2CTL) |=> ctl2_q[`TTC_C_OVF])
        else $error("timer two flag lost");
    a_t2_no_flag: assert property (@(posedge mclk) disable iff (rst)
        baud2 && !ctl2_q[`TTC_C_OVF] && !wr |=> !ctl2_q[`TTC_C_OVF])
        else $error("timer two flag set in baud use");
    a_ext_flag: assert property (@(posedge mclk) disable iff (rst)
        fall_ex && ctl2_q[`TTC_C_EXEN] |=> ctl2_q[`TTC_C_EXF])
        else $error("external flag not set");
    a_t2_wrap: assert property (@(posedge mclk) disable iff (rst)
        en2 && c2_q == 16'hFFFF |=> c2_q == 16'h0000)
        else $error("timer two did not wrap");

    // Serial clocks, interrupt and vectors
    a_baud_rx: assert property (@(posedge mclk) disable iff (rst)
        uart_mode_var && ctl2_q[`TTC_C_RXSEL] && ovf2 |=> baud_q.rx_tick)
        else $error("receive clock missed timer two");
    a_baud_tx: assert property (@(posedge mclk) disable iff (rst)
        uart_mode_var && !ctl2_q[`TTC_C_TXSEL] && t1_roll |=> baud_q.tx_tick)
        else $error("transmit clock missed timer one");
    a_irq_set: assert property (@(posedge mclk) disable iff (rst)
        ctl2_q[`TTC_C_EXF] && t2_irq_enable && global_irq_enable |-> t2_irq)
        else $error("timer two request missing");
    a_vec_clear: assert property (@(posedge mclk) disable iff (rst)
        vector_t1 && !ovf1 && !wr |=> !rf_q[`TTC_RF_OVF1])
        else $error("vector did not clear flag");

    c_split_ovf: cover property (@(posedge mclk) disable iff (rst) split && en0h && n0h[8]);
    c_reload: cover property (@(posedge mclk) disable iff (rst) ovf1 && m1 == ttc_pkg::TTC_MODE_RELOAD);
    c_t2_wrap: cover property (@(posedge mclk) disable iff (rst) ovf2);
    c_ext_flag: cover property (@(posedge mclk) disable iff (rst) fall_ex && ctl2_q[`TTC_C_EXEN]);
    c_t2_ext_count: cover property (@(posedge mclk) disable iff (rst) en2 && ctl2_q[`TTC_C_SRC]);

endmodule

// ==== testbench/test_triple_timer_counter.sv ====
// Self-checking bench for the triple timer counter
`timescale 1ns/1ps
`include "ttc_defs.svh"

module test_triple_timer_counter;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_d = 1'b0;
    logic qual_a = 1'b1;
    logic vec0 = 1'b0;
    logic t2_en = 1'b1;
    logic g_en = 1'b1;
    logic uart_var = 1'b1;
    logic go = 1'b0;
    logic sel = 1'b0;
    logic [3:0] edges = 4'h0;
    logic [7:0] rdata;
    logic pin_a;
    logic trig;
    logic t2_irq;
    logic t0_pulse;
    ttc_pkg::ttc_baud_t baud;
    logic [7:0] q[$];
    logic [15:0] seed = 16'h1981;
    logic [7:0] md [5] = '{8'h01, 8'h02, 8'h00, 8'h03, 8'h0D};
    logic [7:0] hi [5] = '{8'hFF, 8'hA0, 8'hFF, 8'h55, 8'hFF};
    logic [7:0] lo [5] = '{8'hF8, 8'hF8, 8'h18, 8'hF8, 8'hFD};
    logic [7:0] elo [5] = '{8'h00, 8'hA0, 8'h00, 8'h00, 8'h00};
    int fails = 0;
    int total_checks = 0;
    int rxn = 0;
    int txn = 0;
    int n;

    ttc_top uut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .ext_count_pin_a(pin_a), .ext_count_pin_b(pin_a), .qualify_pin_a(qual_a), .qualify_pin_b(qual_a),
        .timer_two_count_pin(pin_a), .timer_two_trigger_pin(trig), .vector_t0(vec0), .vector_t1(vec0),
        .t2_irq_enable(t2_en), .global_irq_enable(g_en), .t2_irq(t2_irq), .uart_mode_var(uart_var),
        .baud(baud), .t0_ovf_pulse(t0_pulse));
    ttc_pins pins (.mclk(mclk), .go(go), .sel(sel), .edges(edges), .cnt_a(pin_a), .trig(trig));

    always #10 mclk = ~mclk;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        q.push_back(e);
        @(posedge mclk);
        rd <= 1'b0;
    endtask
    task automatic start_pins(input logic s, input logic [3:0] k);
        @(posedge mclk);
        sel <= s;
        edges <= k;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
    endtask
    task automatic wait_pulse;
        n = 0;
        while (t0_pulse !== 1'b1 && n < 400) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 400) begin
            fails++;
            complete_run;
        end
    endtask

    // Read results are compared against the oldest note
    always @(posedge mclk) begin
        rd_d <= rd;
        if (rd_d) check(rdata, q.pop_front());
        if (baud.rx_tick === 1'b1) rxn++;
        if (baud.tx_tick === 1'b1) txn++;
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        rd_reg(`TTC_OFF_MODE, 8'h00);
        rd_reg(`TTC_OFF_T2CTL, 8'h00);
        rd_reg(8'h00, 8'h00);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            wr_reg(8'(8'hC9 + i), seed[7:0]);
            rd_reg(8'(8'hC9 + i), seed[7:0]);
        end
        wr_reg(`TTC_OFF_MODE, seed[15:8]);
        rd_reg(`TTC_OFF_MODE, seed[15:8]);
        // Four modes from the timer clock, then pin edges
        for (int i = 0; i < 5; i++) begin
            wr_reg(`TTC_OFF_T0LO, lo[i]);
            wr_reg(`TTC_OFF_T0HI, hi[i]);
            wr_reg(`TTC_OFF_MODE, md[i]);
            wr_reg(`TTC_OFF_RUNFLAG, 8'h10);
            if (i == 4) start_pins(1'b0, 4'h3);
            wait_pulse();
            if (i < 4) check(8'(n >= 40 && n <= 54), 8'h01);
            qual_a <= 1'b0;
            wr_reg(`TTC_OFF_MODE, md[i] | 8'h08);
            rd_reg(`TTC_OFF_T0LO, elo[i]);
            rd_reg(`TTC_OFF_T0HI, (i == 1 || i == 3) ? hi[i] : 8'h00);
            rd_reg(`TTC_OFF_RUNFLAG, 8'h30);
            @(posedge mclk);
            vec0 <= 1'b1;
            @(posedge mclk);
            vec0 <= 1'b0;
            rd_reg(`TTC_OFF_RUNFLAG, 8'h10);
            wr_reg(`TTC_OFF_RUNFLAG, 8'h00);
            qual_a <= 1'b1;
        end
        check(8'(rxn + txn), 8'h00);
        // Timer two plain counting and flags
        wr_reg(`TTC_OFF_T2LO, 8'hF0);
        wr_reg(`TTC_OFF_T2HI, 8'hFF);
        wr_reg(`TTC_OFF_T2CTL, 8'h04);
        repeat (30) @(posedge mclk);
        rd_reg(`TTC_OFF_T2CTL, 8'h84);
        rd_reg(`TTC_OFF_T2HI, 8'h00);
        #1 check(8'(t2_irq), 8'h01);
        @(posedge mclk);
        t2_en <= 1'b0;
        #1 check(8'(t2_irq), 8'h00);
        @(posedge mclk);
        t2_en <= 1'b1;
        g_en <= 1'b0;
        #1 check(8'(t2_irq), 8'h00);
        @(posedge mclk);
        g_en <= 1'b1;
        wr_reg(`TTC_OFF_T2CTL, 8'h08);
        rd_reg(`TTC_OFF_T2CTL, 8'h08);
        start_pins(1'b1, 4'h1);
        repeat (40) @(posedge mclk);
        rd_reg(`TTC_OFF_T2CTL, 8'h48);
        // Timer two counting pin edges
        wr_reg(`TTC_OFF_T2LO, 8'hFE);
        wr_reg(`TTC_OFF_T2HI, 8'hFF);
        wr_reg(`TTC_OFF_T2CTL, 8'h06);
        start_pins(1'b0, 4'h2);
        repeat (60) @(posedge mclk);
        rd_reg(`TTC_OFF_T2CTL, 8'h86);
        rd_reg(`TTC_OFF_T2LO, 8'h00);
        #1 check(8'(t2_irq), 8'h01);
        // Timer two as baud source
        wr_reg(`TTC_OFF_T2LO, 8'hF0);
        wr_reg(`TTC_OFF_T2HI, 8'hFF);
        rxn = 0;
        txn = 0;
        wr_reg(`TTC_OFF_T2CTL, 8'h34);
        repeat (40) @(posedge mclk);
        rd_reg(`TTC_OFF_T2CTL, 8'h34);
        check(8'(rxn > 0 && txn > 0), 8'h01);
        uart_var <= 1'b0;
        wr_reg(`TTC_OFF_T2CTL, 8'h00);
        rxn = 0;
        txn = 0;
        repeat (40) @(posedge mclk);
        check(8'(rxn + txn), 8'h00);
        // Timer one frozen, then baud source, then driven by timer zero split
        uart_var <= 1'b1;
        wr_reg(`TTC_OFF_T1LO, 8'h77);
        wr_reg(`TTC_OFF_MODE, 8'h30);
        wr_reg(`TTC_OFF_RUNFLAG, 8'h40);
        repeat (30) @(posedge mclk);
        rd_reg(`TTC_OFF_T1LO, 8'h77);
        wr_reg(`TTC_OFF_T1HI, 8'hFF);
        wr_reg(`TTC_OFF_T1LO, 8'hFF);
        rxn = 0;
        txn = 0;
        wr_reg(`TTC_OFF_MODE, 8'h20);
        repeat (40) @(posedge mclk);
        check(8'(rxn > 0 && txn > 0), 8'h01);
        wr_reg(`TTC_OFF_RUNFLAG, 8'h00);
        wr_reg(`TTC_OFF_MODE, 8'h23);
        rxn = 0;
        repeat (40) @(posedge mclk);
        check(8'(rxn > 0), 8'h01);
        wr_reg(`TTC_OFF_MODE, 8'h33);
        repeat (2) @(posedge mclk);
        rxn = 0;
        repeat (40) @(posedge mclk);
        check(8'(rxn), 8'h00);
        repeat (3) @(posedge mclk);
        complete_run();
    end
endmodule

// ==== testbench/ttc_pins.sv ====
// External event source for the count and trigger pins
`timescale 1ns/1ps

module ttc_pins (
    // Clock
    input wire logic mclk,
    // Command from the bench
    input wire logic go,
    input wire logic sel,
    input wire logic [3:0] edges,
    // Pins
    output logic cnt_a,
    output logic trig
);
    // ----------------------------------------
    // Edge maker
    // ----------------------------------------
    // Each level is held longer than one machine cycle so every edge is seen
    initial begin
        cnt_a = 1'b1;
        trig = 1'b1;
        forever begin
            @(posedge mclk);
            if (go === 1'b1) begin
                repeat (edges) begin
                    repeat (8) @(posedge mclk);
                    if (sel) trig <= 1'b0;
                    else cnt_a <= 1'b0;
                    repeat (8) @(posedge mclk);
                    trig <= 1'b1;
                    cnt_a <= 1'b1;
                end
            end
        end
    end
endmodule
